// [logic/psm_top.sv]
// Summary of operation
// - Four power states: off, hard reset, always-on, on.
// - Software picks power state and boot mode via registers.
// - Always-on keeps serial ports 1-2 routing, PDM inputs, voice detect clocked.
// - Always-on powers only the low-power peripheral set.
// - Always-on shuts off the core and other blocks.
// - Always-on with memory supply kept retains memory contents.
// - Voice detector wake moves always-on to hard reset, then to on unless always-on is still requested.
// - Memory-supply indicator high while memory supply is wanted.
// - Core-supply indicator high when core supply wanted, else low.
// - Each functional block has its own clock gate.
// - Separate power-down controls for five block groups.
// - Reset low disables all functional blocks.
// - Reset release restores all control registers to defaults.
// - Reset does not clear RAM.
// - Config disable bit turns the linear regulator off.
// - Soft reset restores clock gate, power-down and boot mode defaults; state request, retention and regulator disable are kept.
// - Stay in reset until io, core, memory supplies are good.
//
// Purpose: Power state and reset manager top level
// Assumes: APB register access, single clock pclk
// Notes: RAM is never touched by reset logic
`timescale 1ns/100ps
module psm_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic io_supply_good,
	input wire logic core_supply_good,
	input wire logic memory_supply_good,
	input wire logic vad_wake,
	output logic memory_supply_on_indicator,
	output logic core_supply_on_indicator,
	output logic ldo_enable,
	output logic [15:0] blk_clk_en,
	output logic [4:0] blk_pwr_down_n,
	output logic core_rst_n,
	output logic mem_retain_active,
	output logic [1:0] boot_mode_out
);
	// ----------------------------------------------------------------
	// Reset synchronisation
	// ----------------------------------------------------------------
	logic rst_n;
	logic [1:0] req_state;
	logic [1:0] boot_mode;
	logic mem_retain;
	logic [15:0] clk_gate_en;
	logic [4:0] pd_ctrl;
	logic ldo_disable;
	logic soft_go;
	logic [31:0] stat_word;
	logic supplies_ok;

	psm_rst_sync u_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.rst_n_sync(rst_n)
	);

	assign supplies_ok = io_supply_good && core_supply_good && memory_supply_good;

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------
	psm_pkg::psm_state_e state_r;
	psm_pkg::psm_state_e state_nxt;
	logic [7:0] settle_r;
	logic [7:0] settle_nxt;
	logic wake_r;
	logic wake_nxt;
	logic soft_rst_r;
	logic soft_rst_nxt;

	always_comb
	begin
		state_nxt = state_r;
		settle_nxt = settle_r;
		wake_nxt = wake_r;
		soft_rst_nxt = soft_go;
		unique case (state_r)
			psm_pkg::PS_OFF:
			begin
				if (io_supply_good)
					state_nxt = psm_pkg::PS_HARD_RESET;
			end
			psm_pkg::PS_HARD_RESET:
			begin
				if (!supplies_ok)
					settle_nxt = 8'h00;
				else if (settle_r != 8'(psm_pkg::SUP_SETTLE_CYC))
					settle_nxt = settle_r + 8'h01;
				else if (req_state == psm_pkg::PS_ALWAYS_ON)
					state_nxt = psm_pkg::PS_ALWAYS_ON;
				else
					state_nxt = psm_pkg::PS_ON;
			end
			psm_pkg::PS_ON:
			begin
				settle_nxt = 8'h00;
				if (!io_supply_good)
					state_nxt = psm_pkg::PS_OFF;
				else if (soft_go)
					state_nxt = psm_pkg::PS_HARD_RESET;
				else if (req_state == psm_pkg::PS_ALWAYS_ON)
					state_nxt = psm_pkg::PS_ALWAYS_ON;
			end
			psm_pkg::PS_ALWAYS_ON:
			begin
				settle_nxt = 8'h00;
				if (!io_supply_good)
					state_nxt = psm_pkg::PS_OFF;
				else if (vad_wake)
				begin
					wake_nxt = 1'b1;
					state_nxt = psm_pkg::PS_HARD_RESET;
				end
				else if (req_state == psm_pkg::PS_ON)
					state_nxt = psm_pkg::PS_HARD_RESET;
			end
		endcase
		if (state_r == psm_pkg::PS_ON)
			wake_nxt = 1'b0;
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= psm_pkg::PS_OFF;
			settle_r <= 8'h00;
			wake_r <= 1'b0;
			soft_rst_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			settle_r <= settle_nxt;
			wake_r <= wake_nxt;
			soft_rst_r <= soft_rst_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	assign stat_word = {22'h0, wake_r, mem_retain_active, 1'b0,
		memory_supply_good, core_supply_good, io_supply_good, 2'h0, state_r};

	psm_apb u_apb
	(
		.pclk(pclk),
		.rst_n(rst_n),
		.soft_rst(soft_rst_r),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.stat_word(stat_word),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.req_state(req_state),
		.boot_mode(boot_mode),
		.mem_retain(mem_retain),
		.clk_gate_en(clk_gate_en),
		.pd_ctrl(pd_ctrl),
		.ldo_disable(ldo_disable),
		.soft_go(soft_go)
	);

	// ----------------------------------------------------------------
	// Output control
	// ----------------------------------------------------------------
	logic is_on;
	logic is_aon;
	logic [15:0] gate_nxt;
	logic [4:0] pd_n_nxt;

	assign is_on = (state_r == psm_pkg::PS_ON);
	assign is_aon = (state_r == psm_pkg::PS_ALWAYS_ON);

	genvar gi;
	generate
		for (gi = 0; gi < psm_pkg::NUM_GATES; gi++)
		begin : g_gate
			// Always-on keeps only low-power peripherals clocked
			assign gate_nxt[gi] = clk_gate_en[gi] &&
				(is_on || (is_aon && psm_pkg::AON_GATES[gi]));
		end
	endgenerate

	assign pd_n_nxt = is_on ? ~pd_ctrl : 5'h00;

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memory_supply_on_indicator <= 1'b0;
			core_supply_on_indicator <= 1'b0;
			ldo_enable <= 1'b0;
			blk_clk_en <= 16'h0000;
			blk_pwr_down_n <= 5'h00;
			core_rst_n <= 1'b0;
			mem_retain_active <= 1'b0;
			boot_mode_out <= psm_pkg::RST_BOOT;
		end
		else
		begin
			memory_supply_on_indicator <= is_on || state_r == psm_pkg::PS_HARD_RESET
				|| (is_aon && mem_retain);
			core_supply_on_indicator <= is_on || state_r == psm_pkg::PS_HARD_RESET;
			ldo_enable <= !ldo_disable && state_r != psm_pkg::PS_OFF;
			blk_clk_en <= gate_nxt;
			blk_pwr_down_n <= pd_n_nxt;
			core_rst_n <= is_on && !soft_go;
			mem_retain_active <= is_aon && mem_retain && memory_supply_good;
			boot_mode_out <= boot_mode;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_core_ind;
		@(posedge pclk) disable iff (!rst_n)
		is_aon |=> !core_supply_on_indicator;
	endproperty
	a_core_ind: assert property (p_core_ind) else $error("core indicator high in always-on");

	property p_mem_ind;
		@(posedge pclk) disable iff (!rst_n)
		is_on |=> memory_supply_on_indicator;
	endproperty
	a_mem_ind: assert property (p_mem_ind) else $error("memory indicator low while on");

	property p_wake;
		@(posedge pclk) disable iff (!rst_n)
		is_aon && vad_wake && io_supply_good |=> state_r == psm_pkg::PS_HARD_RESET;
	endproperty
	a_wake: assert property (p_wake) else $error("voice wake not taken");

	property p_aon_gate;
		@(posedge pclk) disable iff (!rst_n)
		is_aon |=> (blk_clk_en & ~psm_pkg::AON_GATES) == 16'h0000;
	endproperty
	a_aon_gate: assert property (p_aon_gate) else $error("non low-power clock on");

	property p_core_off;
		@(posedge pclk) disable iff (!rst_n)
		!is_on |=> !core_rst_n && blk_pwr_down_n == 5'h00;
	endproperty
	a_core_off: assert property (p_core_off) else $error("core active outside on");

	property p_supply_hold;
		@(posedge pclk) disable iff (!rst_n)
		state_r == psm_pkg::PS_HARD_RESET && !supplies_ok |=> state_r != psm_pkg::PS_ON;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("left reset without supplies");

	property p_ldo;
		@(posedge pclk) disable iff (!rst_n)
		ldo_disable |=> !ldo_enable;
	endproperty
	a_ldo: assert property (p_ldo) else $error("regulator on while disabled");

	property p_retain;
		@(posedge pclk) disable iff (!rst_n)
		is_aon && mem_retain && memory_supply_good |=> mem_retain_active;
	endproperty
	a_retain: assert property (p_retain) else $error("retention not held");

	property p_gate;
		@(posedge pclk) disable iff (!rst_n)
		is_on |=> blk_clk_en == $past(clk_gate_en);
	endproperty
	a_gate: assert property (p_gate) else $error("clock gate mismatch");
endmodule

// [pkg/psm_pkg.sv]
// Purpose: Constants for the power state and reset manager
// Assumes: APB slave, 32-bit data, 125 MHz pclk
// Notes: Offsets are byte addresses
package psm_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
	localparam logic [7:0] OFS_PWR_STAT = 8'h04;
	localparam logic [7:0] OFS_CLK_GATE = 8'h08;
	localparam logic [7:0] OFS_PWR_DOWN = 8'h0C;
	localparam logic [7:0] OFS_PWR_CFG = 8'h10;
	localparam logic [7:0] OFS_SOFT_RST = 8'h14;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int CTRL_STATE_LSB = 0;
	localparam int CTRL_BOOT_LSB = 4;
	localparam int CTRL_MEMRET_BIT = 8;
	localparam int CFG_LDO_DIS_BIT = 0;
	localparam int SRST_GO_BIT = 0;
	localparam int STAT_SUP_LSB = 4;
	localparam int STAT_MEMRET_BIT = 8;
	localparam int STAT_WAKE_BIT = 9;
	localparam int NUM_GATES = 16;
	localparam int NUM_PD = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] RST_REQ_STATE = 2'h3;
	localparam logic [1:0] RST_BOOT = 2'h0;
	localparam logic [15:0] RST_CLK_GATE = 16'hFFFF;
	localparam logic [4:0] RST_PWR_DOWN = 5'h00;
	localparam logic [15:0] AON_GATES = 16'h00FF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int SUP_SETTLE_NS = 1000;
	localparam int SUP_SETTLE_CYC = (SUP_SETTLE_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0]
	{
		PS_OFF = 2'b00,
		PS_HARD_RESET = 2'b01,
		PS_ALWAYS_ON = 2'b10,
		PS_ON = 2'b11
	} psm_state_e;

endpackage

// [logic/psm_rst_sync.sv]
// Purpose: Reset synchroniser, async assert and clocked release
// Assumes: presetn active low
// Notes: Two stage
`timescale 1ns/100ps
module psm_rst_sync
(
	input wire logic pclk,
	input wire logic presetn,
	output logic rst_n_sync
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= 1'b1;
			sync_r <= meta_r;
		end
	end

	assign rst_n_sync = sync_r;
endmodule

// [logic/psm_apb.sv]
// Purpose: APB register slave for the power manager
// Assumes: Zero wait state, synchronised reset from sync block
// Notes: Unmapped offsets read zero and raise pslverr
`timescale 1ns/100ps
module psm_apb
(
	input wire logic pclk,
	input wire logic rst_n,
	input wire logic soft_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] stat_word,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [1:0] req_state,
	output logic [1:0] boot_mode,
	output logic mem_retain,
	output logic [15:0] clk_gate_en,
	output logic [4:0] pd_ctrl,
	output logic ldo_disable,
	output logic soft_go
);
	logic wr;
	logic rd;
	logic mapped;
	logic [31:0] rdata_nxt;
	logic err_nxt;
	logic [1:0] req_state_nxt;
	logic [1:0] boot_mode_nxt;
	logic mem_retain_nxt;
	logic [15:0] clk_gate_nxt;
	logic [4:0] pd_nxt;
	logic ldo_nxt;
	logic go_nxt;

	assign wr = psel && penable && pwrite;
	// Read data and error are captured in the setup cycle so they stand through the access cycle
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr == psm_pkg::OFS_PWR_CTRL) || (paddr == psm_pkg::OFS_PWR_STAT)
		|| (paddr == psm_pkg::OFS_CLK_GATE) || (paddr == psm_pkg::OFS_PWR_DOWN)
		|| (paddr == psm_pkg::OFS_PWR_CFG) || (paddr == psm_pkg::OFS_SOFT_RST);
	always_comb
	begin
		req_state_nxt = req_state;
		boot_mode_nxt = boot_mode;
		mem_retain_nxt = mem_retain;
		clk_gate_nxt = clk_gate_en;
		pd_nxt = pd_ctrl;
		ldo_nxt = ldo_disable;
		go_nxt = 1'b0;
		if (soft_rst)
		begin
			clk_gate_nxt = psm_pkg::RST_CLK_GATE;
			pd_nxt = psm_pkg::RST_PWR_DOWN;
			boot_mode_nxt = psm_pkg::RST_BOOT;
		end
		else if (wr)
		begin
			unique case (paddr)
				psm_pkg::OFS_PWR_CTRL:
				begin
					req_state_nxt = pwdata[psm_pkg::CTRL_STATE_LSB +: 2];
					boot_mode_nxt = pwdata[psm_pkg::CTRL_BOOT_LSB +: 2];
					mem_retain_nxt = pwdata[psm_pkg::CTRL_MEMRET_BIT];
				end
				psm_pkg::OFS_CLK_GATE: clk_gate_nxt = pwdata[15:0];
				psm_pkg::OFS_PWR_DOWN: pd_nxt = pwdata[4:0];
				psm_pkg::OFS_PWR_CFG: ldo_nxt = pwdata[psm_pkg::CFG_LDO_DIS_BIT];
				psm_pkg::OFS_SOFT_RST: go_nxt = pwdata[psm_pkg::SRST_GO_BIT];
				default: ;
			endcase
		end
		err_nxt = psel && !penable && !mapped;
		rdata_nxt = prdata;
		if (psel && !penable)
			rdata_nxt = 32'h0000_0000;
		if (rd)
		begin
			unique case (paddr)
				psm_pkg::OFS_PWR_CTRL:
					rdata_nxt = {23'h0, mem_retain, 2'h0, boot_mode, 2'h0, req_state};
				psm_pkg::OFS_PWR_STAT: rdata_nxt = stat_word;
				psm_pkg::OFS_CLK_GATE: rdata_nxt = {16'h0, clk_gate_en};
				psm_pkg::OFS_PWR_DOWN: rdata_nxt = {27'h0, pd_ctrl};
				psm_pkg::OFS_PWR_CFG: rdata_nxt = {31'h0, ldo_disable};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Registers return to defaults through the synchronised reset
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_state <= psm_pkg::RST_REQ_STATE;
			boot_mode <= psm_pkg::RST_BOOT;
			mem_retain <= 1'b1;
			clk_gate_en <= psm_pkg::RST_CLK_GATE;
			pd_ctrl <= psm_pkg::RST_PWR_DOWN;
			ldo_disable <= 1'b0;
			soft_go <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			req_state <= req_state_nxt;
			boot_mode <= boot_mode_nxt;
			mem_retain <= mem_retain_nxt;
			clk_gate_en <= clk_gate_nxt;
			pd_ctrl <= pd_nxt;
			ldo_disable <= ldo_nxt;
			soft_go <= go_nxt;
			prdata <= rdata_nxt;
			pslverr <= err_nxt;
		end
	end
endmodule

// [verif/psm_supply_model.sv]
// Purpose: External supply model, core and memory good flags follow the on indicators, io good tied high
// Assumes: Single clock pclk
// Notes: DLY sets how slowly a supply comes good; hold_mem keeps memory supply down
`timescale 1ns/100ps
module psm_supply_model
#(
	parameter int DLY = 4
)
(
	input wire logic pclk,
	input wire logic core_ind,
	input wire logic mem_ind,
	input wire logic hold_mem,
	output logic io_good,
	output logic core_good,
	output logic mem_good
);
	// ----------------------------------------------------------------
	// Supply ramps
	// ----------------------------------------------------------------
	int core_cnt = 0;
	int mem_cnt = 0;
	assign io_good = 1'b1;
	always @(posedge pclk)
	begin
		core_cnt <= core_ind ? core_cnt + 1 : 0;
		mem_cnt <= (mem_ind && !hold_mem) ? mem_cnt + 1 : 0;
	end
	assign core_good = core_cnt > DLY;
	assign mem_good = mem_cnt > DLY;
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the power state and reset manager
// Assumes: APB master tasks, supply model on the far side
// Notes: Memory clearing after reset is a host duty and is not modelled
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic vad_wake = 1'b0;
	logic hold_mem = 1'b0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, io_g, core_g, mem_g;
	logic mem_ind, core_ind, ldo_enable, core_rst_n, mem_retain_active;
	logic [15:0] blk_clk_en;
	logic [4:0] blk_pwr_down_n;
	logic [1:0] boot_mode_out;
	int failures = 0;
	int tests_run = 0;
	wire logic [27:0] outs = {mem_ind, core_ind, ldo_enable, blk_clk_en, blk_pwr_down_n,
		core_rst_n, mem_retain_active, boot_mode_out};
	always #4 pclk = ~pclk;

	psm_top i_psm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .io_supply_good(io_g), .core_supply_good(core_g),
		.memory_supply_good(mem_g), .vad_wake(vad_wake), .memory_supply_on_indicator(mem_ind),
		.core_supply_on_indicator(core_ind), .ldo_enable(ldo_enable), .blk_clk_en(blk_clk_en),
		.blk_pwr_down_n(blk_pwr_down_n), .core_rst_n(core_rst_n),
		.mem_retain_active(mem_retain_active), .boot_mode_out(boot_mode_out));
	psm_supply_model #(.DLY(4)) i_psm_supply_model (.pclk(pclk), .core_ind(core_ind),
		.mem_ind(mem_ind), .hold_mem(hold_mem), .io_good(io_g), .core_good(core_g),
		.mem_good(mem_g));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task stop_test;
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rerr = pslverr;
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task wait_core(input logic lvl);
		int n;
		n = 0;
		while (core_rst_n !== lvl && n < 1000)
		begin
			@(negedge pclk);
			n++;
		end
		chk({31'h0, core_rst_n}, {31'h0, lvl});
	endtask
	task hw_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk({4'h0, outs}, 32'h0);
		chk({31'h0, pready}, 32'h1);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({4'h0, outs}, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		#100000;
		failures++;
		stop_test;
	end
	initial
	begin
		hw_reset;
		wait_core(1'b1);
		rdc(psm_pkg::OFS_PWR_STAT, 32'h73);
		chk({29'h0, mem_ind, core_ind, ldo_enable}, 32'h7);
		chk({16'h0, blk_clk_en}, 32'hFFFF);
		chk({27'h0, blk_pwr_down_n}, 32'h1F);
		rdc(psm_pkg::OFS_PWR_CTRL, 32'h103);
		rdc(psm_pkg::OFS_CLK_GATE, 32'hFFFF);
		rdc(psm_pkg::OFS_PWR_DOWN, 32'h0);
		rdc(psm_pkg::OFS_PWR_CFG, 32'h0);
		rdc(8'h18, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		wr(psm_pkg::OFS_CLK_GATE, 32'h1234);
		wr(psm_pkg::OFS_PWR_DOWN, 32'h05);
		wr(psm_pkg::OFS_PWR_CTRL, 32'h123);
		wr(psm_pkg::OFS_PWR_CFG, 32'h1);
		repeat (2) @(negedge pclk);
		chk({16'h0, blk_clk_en}, 32'h1234);
		chk({27'h0, blk_pwr_down_n}, 32'h1A);
		chk({30'h0, boot_mode_out}, 32'h2);
		chk({31'h0, ldo_enable}, 32'h0);
		wr(psm_pkg::OFS_PWR_CFG, 32'h0);
		wr(psm_pkg::OFS_PWR_STAT, 32'hFFFF);
		rdc(psm_pkg::OFS_PWR_CTRL, 32'h123);
		wr(psm_pkg::OFS_PWR_CTRL, 32'h102);
		wait_core(1'b0);
		repeat (12) @(negedge pclk);
		chk({30'h0, mem_ind, core_ind}, 32'h2);
		chk({31'h0, mem_retain_active}, 32'h1);
		chk({16'h0, blk_clk_en}, 32'h34);
		chk({27'h0, blk_pwr_down_n}, 32'h0);
		rdc(psm_pkg::OFS_PWR_STAT, 32'h152);
		wr(psm_pkg::OFS_PWR_CTRL, 32'h002);
		repeat (8) @(negedge pclk);
		chk({30'h0, mem_ind, mem_retain_active}, 32'h0);
		@(posedge pclk);
		vad_wake <= 1'b1;
		@(posedge pclk);
		vad_wake <= 1'b0;
		wr(psm_pkg::OFS_PWR_CTRL, 32'h103);
		rdc(psm_pkg::OFS_PWR_STAT, 32'h211);
		wait_core(1'b1);
		rdc(psm_pkg::OFS_PWR_STAT, 32'h073);
		wr(psm_pkg::OFS_PWR_CFG, 32'h1);
		wr(psm_pkg::OFS_PWR_CTRL, 32'h113);
		wr(psm_pkg::OFS_CLK_GATE, 32'h0F0F);
		wr(psm_pkg::OFS_SOFT_RST, 32'h1);
		wait_core(1'b0);
		wait_core(1'b1);
		rdc(psm_pkg::OFS_CLK_GATE, 32'hFFFF);
		rdc(psm_pkg::OFS_PWR_CTRL, 32'h103);
		rdc(psm_pkg::OFS_PWR_CFG, 32'h1);
		chk({31'h0, ldo_enable}, 32'h0);
		hold_mem <= 1'b1;
		hw_reset;
		repeat (300) @(negedge pclk);
		chk({31'h0, core_rst_n}, 32'h0);
		@(posedge pclk);
		hold_mem <= 1'b0;
		wait_core(1'b1);
		rdc(psm_pkg::OFS_PWR_CFG, 32'h0);
		rdc(psm_pkg::OFS_CLK_GATE, 32'hFFFF);
		stop_test;
	end
endmodule
